// ==== bench/pin_partner.sv ====
// pin model of the phy management line and the serial eeprom, data lines pulled up, clock line pulled up or down by the strap
`timescale 1ns/1ps
module pin_partner (
  input wire logic ck_oe_in,
  input wire logic ck_in,
  input wire logic ed_oe_in,
  input wire logic ed_in,
  input wire logic md_oe_in,
  input wire logic md_in,
  input wire logic low_in,
  input wire logic strap_low_in,
  output logic ck_out,
  output logic ed_out,
  output logic md_out
);
  // pull-up on the clock line straps the port present; a pull-down straps it absent
  assign ck_out = ck_oe_in ? ck_in : !strap_low_in;
  // eeprom stays off its data line, so the pull-up shows
  assign ed_out = ed_oe_in ? ed_in : 1'b1;
  // the phy pulls mdio low to flag an event while nobody drives it
  assign md_out = md_oe_in ? md_in : !low_in;
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the network control register word
`timescale 1ns/1ps
module tb_top;
  import netctl_pkg::*;
  // ==========================================================================
  // stimulus and observation
  logic clk = 0, nrst = 0, ares = 0, nvw = 0, nvd = 0, gap = 0, txs = 0, rxs = 0, low = 0;
  logic col = 0, csma = 1, pass_error_frames = 0, strap = 0;
  dio_req_t req = '0;
  tx_result_t txr = '0;
  rx_frame_t rxf = '0;
  mac_ctrl_t mc;
  logic ack, dv, acc, eck, ecko, ecoe, ed, edo, edoe, en, mck, md, mdo, mdoe, phy, irq;
  logic [31:0] rdata, rd;
  logic [2:0] ifg, ity;
  logic [7:0] ivec;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #20 clk = ~clk;
  network_control_status_regs i_dut (.sys_clk_in(clk), .nrst_in(nrst), .adapter_reset_in(ares),
    .dio_req_in(req), .dio_ack_out(ack), .dio_rdata_out(rdata), .nvram_write_in(nvw),
    .nvram_clock_in(1'b0), .nvram_data_in(1'b0), .nvram_drive_in(nvd), .csma_mode_in(csma),
    .pass_error_frames_in(pass_error_frames), .tx_result_in(txr), .post_tx_gap_in(gap),
    .tx_stop_done_in(txs), .rx_stop_done_in(rxs), .rx_frame_in(rxf),
    .rx_decision_valid_out(dv), .rx_accept_out(acc), .mac_ctrl_out(mc), .ifg_multiple_out(ifg),
    .collision_input_pin_in(col), .eeprom_clock_pin_in(eck), .eeprom_clock_pin_out(ecko),
    .eeprom_clock_pin_oe_out(ecoe), .eeprom_data_pin_in(ed), .eeprom_data_pin_out(edo),
    .eeprom_data_pin_oe_out(edoe), .eeprom_port_enabled_out(en), .mgmt_clock_pin_out(mck),
    .mgmt_data_pin_in(md), .mgmt_data_pin_out(mdo), .mgmt_data_pin_oe_out(mdoe),
    .phy_reset_pin_n_out(phy), .net_irq_out(irq), .int_type_out(ity), .int_vec_out(ivec));
  pin_partner i_pins (.ck_oe_in(ecoe), .ck_in(ecko), .ed_oe_in(edoe), .ed_in(edo),
    .md_oe_in(mdoe), .md_in(mdo), .low_in(low), .strap_low_in(strap), .ck_out(eck),
    .ed_out(ed), .md_out(md));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one indirect bus transfer; ack must follow one cycle after the request
  task automatic indirect_register_bus(input logic wr, input logic [6:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge clk) #1 req = '{1'b1, wr, a, be, d};
    @(posedge clk) #1 req.valid = 0;
    check(ack, 1);
    rd = rdata;
  endtask
  task automatic t_cmd();
    indirect_register_bus(0, 0, 4'hf, 0);
    check(rd & 32'hffffeeff, 0);
    check({mc.hold_reset, mc.internal_loopback, phy, en, ity}, 7'h68);
    indirect_register_bus(1, 0, 4'h1, 32'h46);
    indirect_register_bus(1, 0, 4'h1, 32'hc6);
    check({mc.hold_reset, mc.config_write_allow, mc.internal_loopback, mc.mac_clock_from_pci,
      mc.mii_pins_enable, mc.full_duplex, mc.collision_stats_enable, mc.ring_frame_format},
      8'h0d);
    indirect_register_bus(1, 7'h04, 4'hf, 32'hffffffff);
    check(rd, 0);
  endtask
  task automatic t_rx();
    logic [7:0] c [7] = '{8'hc8, 8'hc8, 8'hc0, 8'hd0, 8'hd0, 8'he0, 8'hc0};
    logic [5:0] f [7] = '{6'h28, 6'h24, 6'h28, 6'h20, 6'h22, 6'h31, 6'h31};
    logic [6:0] e = 7'b0011010;
    for (int i = 0; i < 7; i++)
    begin
      indirect_register_bus(1, 0, 4'h1, {24'h0, c[i]});
      check({mc.keep_short_frames, mc.promiscuous, mc.reject_broadcast}, c[i][5:3]);
      @(posedge clk) #1 rxf = f[i];
      @(posedge clk) #1 rxf = '0;
      check({dv, acc}, {1'b1, e[6-i]});
    end
    // outside csma the keep bit is void; promiscuous with pass flag takes error frames
    csma = 0;
    pass_error_frames = 1;
    indirect_register_bus(1, 0, 4'h1, 32'hf0);
    @(posedge clk) #1 rxf = 6'h23;
    @(posedge clk) #1 rxf = '0;
    check({dv, acc, mc.keep_short_frames, mc.promiscuous}, 4'hd);
    csma = 1;
    pass_error_frames = 0;
  endtask
  task automatic t_sio();
    indirect_register_bus(1, 0, 4'h2, 32'h7f00);
    check({phy, mck, mdoe, mdo, ecoe, ecko, edoe, edo}, 8'hff);
    @(posedge clk) #1 nvw = 1;
    @(posedge clk) #1 nvw = 0;
    check(edoe, 0);
    indirect_register_bus(1, 0, 4'h2, 0);
    tick(3);
    indirect_register_bus(0, 0, 4'h2, 0);
    check({phy, rd[15:8]}, 9'h011);
  endtask
  // every flag source at once, then write-one-to-clear
  task automatic t_sts();
    indirect_register_bus(1, 0, 4'hc, 32'hff000000);
    indirect_register_bus(1, 0, 4'h2, 32'h8000);
    low = 1;
    gap = 1;
    txs = 1;
    rxs = 1;
    tick(1);
    txs = 0;
    rxs = 0;
    gap = 0;
    tick(5);
    indirect_register_bus(0, 0, 4'hf, 0);
    check({rd[31:16], irq, ity, ivec}, {16'hf0f0, 1'b1, 3'b110, 8'h00});
    low = 0;
    indirect_register_bus(1, 0, 4'h2, 0);
    indirect_register_bus(1, 0, 4'h4, 0);
    indirect_register_bus(0, 0, 4'h4, 0);
    check(rd[23:16], 8'hf0);
    indirect_register_bus(1, 0, 4'h4, 32'h00ff0000);
    indirect_register_bus(0, 0, 4'h4, 0);
    check({rd[23:16], irq}, 0);
    // a collision seen inside the gap must suppress the heartbeat flag
    col = 1;
    gap = 1;
    tick(3);
    col = 0;
    gap = 0;
    tick(2);
    indirect_register_bus(0, 0, 4'h4, 0);
    check(rd[23:20], 0);
  endtask
  task automatic t_pace();
    indirect_register_bus(1, 0, 4'h1, 32'hc1);
    txr = 3'b101;
    tick(1);
    txr = 3'b100;
    tick(30);
    check(ifg, 4);
    tick(1);
    txr = 0;
    check(ifg, 1);
  endtask
  task automatic t_ares();
    indirect_register_bus(1, 0, 4'h2, 32'h2000);
    nvd = 1;
    ares = 1;
    strap = 1;
    tick(1);
    ares = 0;
    indirect_register_bus(0, 0, 4'hf, 0);
    check(rd & 32'hffffeeff, 0);
    check({edoe, mc.hold_reset}, 2'b11);
    // clock line strapped low across the restart: port disabled, clock bit reads zero
    tick(3);
    strap = 0;
    indirect_register_bus(1, 0, 4'h2, 32'h4000);
    indirect_register_bus(0, 0, 4'h2, 0);
    check({en, ecoe, rd[14]}, 0);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far above the roughly 130 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    tick(4);
    t_cmd();
    t_rx();
    t_sio();
    t_sts();
    t_pace();
    t_ares();
    conclude();
  end
endmodule

// ==== rtl/netctl_pkg.sv ====
// constants, field layout and carrier types shared by the network control register bank
package netctl_pkg;

  // ==========================================================================
  // register word location on the internal indirect bus
  // ==========================================================================
  localparam logic [4:0] NET_WORD_INDEX = 5'h00;  // word at byte offset 0x00
  localparam int NET_ADDR_MSB = 6;
  localparam int NET_ADDR_LSB = 2;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] NET_CMD_RESET = 8'h00;
  localparam logic [7:0] NET_SIO_RESET = 8'h00;
  localparam logic [3:0] NET_STS_RESET = 4'h0;
  localparam logic [3:0] NET_MASK_RESET = 4'h0;

  // ==========================================================================
  // network_command bits (byte 0)
  // ==========================================================================
  localparam int CMD_CONTROLLER_RUN = 7;
  localparam int CMD_EXTERNAL_PATH_SELECT = 6;
  localparam int CMD_KEEP_SHORT_FRAMES = 5;
  localparam int CMD_PROMISCUOUS_RECEIVE = 4;
  localparam int CMD_REJECT_BROADCAST = 3;
  localparam int CMD_FULL_DUPLEX = 2;
  localparam int CMD_RING_FRAME_FORMAT = 1;
  localparam int CMD_TRANSMIT_PACING_ENABLE = 0;

  // ==========================================================================
  // serial_pin_control bits, relative to byte 1 (absolute bit minus 8)
  // ==========================================================================
  localparam int SIO_MGMT_IRQ_ENABLE = 7;
  localparam int SIO_EEPROM_CLOCK_BIT = 6;
  localparam int SIO_EEPROM_DRIVE_ENABLE = 5;
  localparam int SIO_EEPROM_DATA_BIT = 4;
  localparam int SIO_PHY_RESET_RELEASE = 3;
  localparam int SIO_MGMT_CLOCK_BIT = 2;
  localparam int SIO_MGMT_DRIVE_ENABLE = 1;
  localparam int SIO_MGMT_DATA_BIT = 0;

  // ==========================================================================
  // status flags (bits 23..20) and masks (bits 31..28), relative index
  // ==========================================================================
  localparam int STS_MGMT_IRQ = 3;
  localparam int STS_HEARTBEAT_ERROR = 2;
  localparam int STS_TRANSMIT_STOPPED = 1;
  localparam int STS_RECEIVE_STOPPED = 0;
  localparam int STS_FIELD_LSB = 20;
  localparam int MASK_FIELD_LSB = 28;

  // ==========================================================================
  // host interrupt report and transmit pacing
  // ==========================================================================
  localparam logic [2:0] INT_TYPE_NET_STATUS = 3'b110;
  localparam logic [2:0] INT_TYPE_NONE = 3'b000;
  localparam logic [7:0] INT_VEC_NET_STATUS = 8'h00;
  localparam logic [2:0] IFG_NORMAL = 3'h1;
  localparam logic [2:0] IFG_PACED = 3'h4;            // four interframe gaps
  localparam logic [4:0] PACE_CLEAN_FRAMES = 5'h1f;   // 31 clean frames end pacing

  // ==========================================================================
  // carrier types
  // ==========================================================================
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } dio_req_t;

  typedef struct packed {
    logic done;
    logic collided;
    logic deferred;
  } tx_result_t;

  typedef struct packed {
    logic valid;
    logic addr_match;
    logic broadcast;
    logic ring_broadcast;
    logic error;
    logic short_frame;
  } rx_frame_t;

  typedef struct packed {
    logic hold_reset;
    logic config_write_allow;
    logic internal_loopback;
    logic mac_clock_from_pci;
    logic mii_pins_enable;
    logic keep_short_frames;
    logic promiscuous;
    logic reject_broadcast;
    logic full_duplex;
    logic collision_stats_enable;
    logic ring_frame_format;
  } mac_ctrl_t;

  typedef enum logic [1:0] {
    STRAP_SETTLE0 = 2'b00,
    STRAP_SETTLE1 = 2'b01,
    STRAP_SETTLE2 = 2'b11,
    STRAP_DONE = 2'b10
  } strap_state_t;

endpackage

// ==== rtl/network_control_status_regs.sv ====
// network command, serial pin, status and mask byte registers on the indirect bus
//
// Behaviour
// - reset clears all four bytes
// - run clear holds controller reset, unlocks config
// - path select clear loops back internally
// - keep short frames only in csma mode
// - promiscuous accepts all non-broadcast, errors need pass flag, short frames need keep bit in csma
// - reject broadcast drops broadcast frames when set
// - full duplex disables collision statistics
// - ring frame format selects ring framing
// - pacing: four gaps until 31 clean frames
// - eeprom pins follow most recent writer
// - any reset gives eeprom pins to nvram
// - eeprom clock bit, strap disables port
// - eeprom data driven or loaded by enable
// - phy reset pin follows release bit
// - mgmt clock bit drives mgmt clock pin
// - mdio driven or loaded by enable
// - mdio low with enable sets mgmt flag
// - missing collision in gap sets heartbeat, csma only
// - stop completions set stop flags
// - status flags clear on write one
// - masked flags post network status interrupt
// - report type 110 with zero vector
`timescale 1ns/1ps
module network_control_status_regs (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic adapter_reset_in,
  input wire netctl_pkg::dio_req_t dio_req_in,
  output logic dio_ack_out,
  output logic [31:0] dio_rdata_out,
  input wire logic nvram_write_in,
  input wire logic nvram_clock_in,
  input wire logic nvram_data_in,
  input wire logic nvram_drive_in,
  input wire logic csma_mode_in,
  input wire logic pass_error_frames_in,
  input wire netctl_pkg::tx_result_t tx_result_in,
  input wire logic post_tx_gap_in,
  input wire logic tx_stop_done_in,
  input wire logic rx_stop_done_in,
  input wire netctl_pkg::rx_frame_t rx_frame_in,
  output logic rx_decision_valid_out,
  output logic rx_accept_out,
  output netctl_pkg::mac_ctrl_t mac_ctrl_out,
  output logic [2:0] ifg_multiple_out,
  input wire logic collision_input_pin_in,
  input wire logic eeprom_clock_pin_in,
  output logic eeprom_clock_pin_out,
  output logic eeprom_clock_pin_oe_out,
  input wire logic eeprom_data_pin_in,
  output logic eeprom_data_pin_out,
  output logic eeprom_data_pin_oe_out,
  output logic eeprom_port_enabled_out,
  output logic mgmt_clock_pin_out,
  input wire logic mgmt_data_pin_in,
  output logic mgmt_data_pin_out,
  output logic mgmt_data_pin_oe_out,
  output logic phy_reset_pin_n_out,
  output logic net_irq_out,
  output logic [2:0] int_type_out,
  output logic [7:0] int_vec_out
);
  import netctl_pkg::*;

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [3:0] pins_sync;
  logic col_sync;
  logic eclk_sync;
  logic eeprom_data_pin_sync;
  logic mdio_sync;

  pin_sync #(.WIDTH(4)) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .pin_in({collision_input_pin_in, eeprom_clock_pin_in, eeprom_data_pin_in,
             mgmt_data_pin_in}),
    .sync_out(pins_sync)
  );
  assign {col_sync, eclk_sync, eeprom_data_pin_sync, mdio_sync} = pins_sync;

  // ==========================================================================
  // address decode
  // ==========================================================================
  logic [7:0] cmd_r;
  logic [7:0] sio_r;
  logic [7:0] sio_nxt;
  logic [3:0] sts_r;
  logic [3:0] sts_nxt;
  logic [3:0] mask_r;
  logic [3:0] sts_set;
  logic [3:0] sts_clr;
  logic wr_hit;
  logic rd_hit;
  logic owner_sio_r;
  logic eeprom_enabled_r;
  strap_state_t strap_r;

  // one word only; other word addresses belong to neighbouring registers
  function automatic logic word_hit(input logic [6:0] addr);
    word_hit = (addr[NET_ADDR_MSB:NET_ADDR_LSB] == NET_WORD_INDEX);
  endfunction

  assign wr_hit = dio_req_in.valid & dio_req_in.write & word_hit(dio_req_in.addr);
  assign rd_hit = dio_req_in.valid & ~dio_req_in.write & word_hit(dio_req_in.addr);

  // ==========================================================================
  // network_command byte
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cmd_r <= NET_CMD_RESET;
    else if (adapter_reset_in)
      cmd_r <= NET_CMD_RESET;
    else if (wr_hit && dio_req_in.byte_en[0])
      cmd_r <= dio_req_in.wdata[7:0];
  end

  // command bits decoded into the mac control bundle
  always_comb
  begin
    mac_ctrl_out.hold_reset = ~cmd_r[CMD_CONTROLLER_RUN];
    mac_ctrl_out.config_write_allow = ~cmd_r[CMD_CONTROLLER_RUN];
    mac_ctrl_out.internal_loopback = ~cmd_r[CMD_EXTERNAL_PATH_SELECT];
    mac_ctrl_out.mac_clock_from_pci = ~cmd_r[CMD_EXTERNAL_PATH_SELECT];
    mac_ctrl_out.mii_pins_enable = cmd_r[CMD_EXTERNAL_PATH_SELECT];
    mac_ctrl_out.keep_short_frames = cmd_r[CMD_KEEP_SHORT_FRAMES] & csma_mode_in;
    mac_ctrl_out.promiscuous = cmd_r[CMD_PROMISCUOUS_RECEIVE];
    mac_ctrl_out.reject_broadcast = cmd_r[CMD_REJECT_BROADCAST];
    mac_ctrl_out.full_duplex = cmd_r[CMD_FULL_DUPLEX];
    mac_ctrl_out.collision_stats_enable = ~cmd_r[CMD_FULL_DUPLEX];
    mac_ctrl_out.ring_frame_format = cmd_r[CMD_RING_FRAME_FORMAT];
  end

  // ==========================================================================
  // receive accept decision
  // ==========================================================================
  function automatic logic frame_accept(input rx_frame_t f, input logic [7:0] cmd,
                                        input logic csma, input logic pass_error_frames);
    logic bcast;
    bcast = f.broadcast | f.ring_broadcast;
    if (f.error && !(cmd[CMD_PROMISCUOUS_RECEIVE] && pass_error_frames))
      frame_accept = 1'b0;
    else if (f.short_frame && csma && !cmd[CMD_KEEP_SHORT_FRAMES])
      frame_accept = 1'b0;
    else if (bcast)
      frame_accept = ~cmd[CMD_REJECT_BROADCAST];
    else
      frame_accept = f.addr_match | cmd[CMD_PROMISCUOUS_RECEIVE];
  endfunction

  // the decision is registered so the filter sees one stable answer per frame
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_decision_valid_out <= 1'b0;
      rx_accept_out <= 1'b0;
    end
    else
    begin
      rx_decision_valid_out <= rx_frame_in.valid;
      rx_accept_out <= rx_frame_in.valid &
                       frame_accept(rx_frame_in, cmd_r, csma_mode_in, pass_error_frames_in);
    end
  end

  // ==========================================================================
  // transmit pacing
  // ==========================================================================
  logic pace_on_r;
  logic [4:0] clean_cnt_r;

  // a collision or deferral restarts the clean-frame run
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pace_on_r <= 1'b0;
      clean_cnt_r <= 5'h00;
    end
    else if (adapter_reset_in || !cmd_r[CMD_TRANSMIT_PACING_ENABLE])
    begin
      pace_on_r <= 1'b0;
      clean_cnt_r <= 5'h00;
    end
    else if (tx_result_in.done)
    begin
      if (tx_result_in.collided || tx_result_in.deferred)
      begin
        pace_on_r <= 1'b1;
        clean_cnt_r <= 5'h00;
      end
      else if (pace_on_r)
      begin
        if (clean_cnt_r == PACE_CLEAN_FRAMES - 5'h01)
        begin
          pace_on_r <= 1'b0;
          clean_cnt_r <= 5'h00;
        end
        else
          clean_cnt_r <= clean_cnt_r + 5'h01;
      end
    end
  end
  assign ifg_multiple_out = pace_on_r ? IFG_PACED : IFG_NORMAL;

  // ==========================================================================
  // serial_pin_control byte
  // ==========================================================================
  // data bits follow their pins whenever the matching drive enable is off
  always_comb
  begin
    sio_nxt = sio_r;
    if (wr_hit && dio_req_in.byte_en[1])
      sio_nxt = dio_req_in.wdata[15:8];
    if (!sio_nxt[SIO_EEPROM_DRIVE_ENABLE])
      sio_nxt[SIO_EEPROM_DATA_BIT] = eeprom_data_pin_sync;
    if (!sio_nxt[SIO_MGMT_DRIVE_ENABLE])
      sio_nxt[SIO_MGMT_DATA_BIT] = mdio_sync;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sio_r <= NET_SIO_RESET;
    else if (adapter_reset_in)
      sio_r <= NET_SIO_RESET;
    else
      sio_r <= sio_nxt;
  end

  // eeprom pin owner: nvram side on reset or its write, serial byte on a window write
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      owner_sio_r <= 1'b0;
    else if (adapter_reset_in || nvram_write_in)
      owner_sio_r <= 1'b0;
    else if (wr_hit)
      owner_sio_r <= 1'b1;
  end

  // strap sample: wait for the synchroniser to see the undriven pin, then latch
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      strap_r <= STRAP_SETTLE0;
      eeprom_enabled_r <= 1'b0;
    end
    else if (adapter_reset_in)
    begin
      strap_r <= STRAP_SETTLE0;
      eeprom_enabled_r <= 1'b0;
    end
    else
    begin
      case (strap_r)
        STRAP_SETTLE0: strap_r <= STRAP_SETTLE1;
        STRAP_SETTLE1: strap_r <= STRAP_SETTLE2;
        STRAP_SETTLE2:
        begin
          strap_r <= STRAP_DONE;
          eeprom_enabled_r <= eclk_sync;
        end
        STRAP_DONE: strap_r <= STRAP_DONE;
        default: strap_r <= STRAP_SETTLE0;
      endcase
    end
  end

  // pin drive; clock pin stays undriven while the strap is being read
  assign eeprom_port_enabled_out = eeprom_enabled_r;
  assign eeprom_clock_pin_oe_out = eeprom_enabled_r;
  assign eeprom_clock_pin_out = owner_sio_r ? sio_r[SIO_EEPROM_CLOCK_BIT] : nvram_clock_in;
  assign eeprom_data_pin_out = owner_sio_r ? sio_r[SIO_EEPROM_DATA_BIT] : nvram_data_in;
  assign eeprom_data_pin_oe_out = owner_sio_r ? sio_r[SIO_EEPROM_DRIVE_ENABLE] : nvram_drive_in;
  assign phy_reset_pin_n_out = sio_r[SIO_PHY_RESET_RELEASE];
  assign mgmt_clock_pin_out = sio_r[SIO_MGMT_CLOCK_BIT];
  assign mgmt_data_pin_out = sio_r[SIO_MGMT_DATA_BIT];
  assign mgmt_data_pin_oe_out = sio_r[SIO_MGMT_DRIVE_ENABLE];

  // ==========================================================================
  // status flags and masks
  // ==========================================================================
  logic gap_r;
  logic col_seen_r;

  // collision must show somewhere inside the gap window after a transmission
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gap_r <= 1'b0;
      col_seen_r <= 1'b0;
    end
    else
    begin
      gap_r <= post_tx_gap_in;
      if (!gap_r && post_tx_gap_in)
        col_seen_r <= col_sync;
      else if (post_tx_gap_in)
        col_seen_r <= col_seen_r | col_sync;
    end
  end

  always_comb
  begin
    sts_set[STS_MGMT_IRQ] = ~mdio_sync & sio_r[SIO_MGMT_IRQ_ENABLE];
    sts_set[STS_HEARTBEAT_ERROR] = csma_mode_in & gap_r & ~post_tx_gap_in
                                   & ~(col_seen_r | col_sync);
    sts_set[STS_TRANSMIT_STOPPED] = tx_stop_done_in;
    sts_set[STS_RECEIVE_STOPPED] = rx_stop_done_in;
    sts_clr = (wr_hit && dio_req_in.byte_en[2]) ? dio_req_in.wdata[23:20] : 4'h0;
    sts_nxt = (sts_r & ~sts_clr) | sts_set; // set wins over clear
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sts_r <= NET_STS_RESET;
    else if (adapter_reset_in)
      sts_r <= NET_STS_RESET;
    else
      sts_r <= sts_nxt;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mask_r <= NET_MASK_RESET;
    else if (adapter_reset_in)
      mask_r <= NET_MASK_RESET;
    else if (wr_hit && dio_req_in.byte_en[3])
      mask_r <= dio_req_in.wdata[31:28]; // bits 27..24 dropped
  end

  // interrupt report is registered, one cycle behind the flags
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      net_irq_out <= 1'b0;
      int_type_out <= INT_TYPE_NONE;
      int_vec_out <= INT_VEC_NET_STATUS;
    end
    else
    begin
      net_irq_out <= |(sts_r & mask_r);
      int_type_out <= (|(sts_r & mask_r)) ? INT_TYPE_NET_STATUS : INT_TYPE_NONE;
      int_vec_out <= INT_VEC_NET_STATUS;
    end
  end

  // ==========================================================================
  // read path: one-cycle answer, unmapped words read zero
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dio_ack_out <= 1'b0;
      dio_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      dio_ack_out <= dio_req_in.valid;
      if (rd_hit)
        dio_rdata_out <= {mask_r, 4'h0, sts_r, 4'h0,
                          sio_r[7], sio_r[6] & eeprom_enabled_r, sio_r[5:0], cmd_r};
      else
        dio_rdata_out <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_adapter_reset_clear: assert property (adapter_reset_in |=>
    (cmd_r == 8'h00) && (sio_r[7:1] == 7'h00) && (sts_r == 4'h0) && (mask_r == 4'h0))
    else $error("adapter reset did not clear registers");
  a_run_locks_config: assert property (wr_hit && dio_req_in.byte_en[0] &&
    dio_req_in.wdata[CMD_CONTROLLER_RUN] && !adapter_reset_in |=>
    !mac_ctrl_out.config_write_allow && !mac_ctrl_out.hold_reset)
    else $error("run bit did not release controller");
  a_loopback_pins: assert property (mac_ctrl_out.internal_loopback ==
    !mac_ctrl_out.mii_pins_enable) else $error("loopback and pin enable disagree");
  a_short_csma_only: assert property (!csma_mode_in |->
    !mac_ctrl_out.keep_short_frames) else $error("short frame keep outside csma");
  a_bcast_reject: assert property (rx_frame_in.valid && rx_frame_in.broadcast &&
    cmd_r[CMD_REJECT_BROADCAST] |=> rx_decision_valid_out && !rx_accept_out)
    else $error("broadcast frame accepted");
  a_promisc_accept: assert property (rx_frame_in.valid && !rx_frame_in.error &&
    !rx_frame_in.broadcast && !rx_frame_in.ring_broadcast && !rx_frame_in.short_frame &&
    cmd_r[CMD_PROMISCUOUS_RECEIVE] |=> rx_accept_out)
    else $error("promiscuous frame rejected");
  a_pace_start: assert property (tx_result_in.done && tx_result_in.collided &&
    cmd_r[CMD_TRANSMIT_PACING_ENABLE] && !adapter_reset_in && !(wr_hit &&
    dio_req_in.byte_en[0]) |=> ifg_multiple_out == IFG_PACED)
    else $error("pacing not started after collision");
  a_flag_set_wins: assert property ((|sts_set) && !adapter_reset_in |=>
    ((sts_r & $past(sts_set)) == $past(sts_set))) else $error("status event lost");
  a_mdio_load: assert property (!sio_nxt[SIO_MGMT_DRIVE_ENABLE] && !adapter_reset_in |=>
    sio_r[SIO_MGMT_DATA_BIT] == $past(mdio_sync)) else $error("mdio not loaded");
  a_owner_window: assert property (wr_hit && !nvram_write_in && !adapter_reset_in |=>
    owner_sio_r ##0 (eeprom_clock_pin_out == sio_r[SIO_EEPROM_CLOCK_BIT]))
    else $error("window write did not take eeprom pins");
  a_irq_report: assert property ((|(sts_r & mask_r)) |=> net_irq_out &&
    (int_type_out == INT_TYPE_NET_STATUS) && (int_vec_out == 8'h00))
    else $error("network status interrupt not posted");

  c_pacing_on: cover property (!pace_on_r ##1 pace_on_r);
  c_mgmt_irq: cover property (sts_set[STS_MGMT_IRQ] ##1 net_irq_out);
  c_bcast_drop: cover property (rx_frame_in.valid && rx_frame_in.broadcast ##1 !rx_accept_out);
  c_owner_swap: cover property (owner_sio_r ##1 !owner_sio_r);

endmodule

// ==== rtl/pin_sync.sv ====
// two-flop synchronisers for the pins sampled by the register bank
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // one pair of flops per pin; the first flop feeds only the second
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_r;
      logic stable_r;
      always_ff @(posedge sys_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end
        else
        begin
          meta_r <= pin_in[i];
          stable_r <= meta_r;
        end
      end
      assign sync_out[i] = stable_r;
    end
  endgenerate

endmodule
